//--- logic/sptx_cfg.svh
`ifndef SPTX_CFG_SVH
`define SPTX_CFG_SVH

// ==========================================================================
// Register map.
`define SPTX_ADDR_W 8
`define SPTX_OFF_CTRL 8'h00
`define SPTX_OFF_STATUS 8'h04
`define SPTX_OFF_LEFT 8'h08
`define SPTX_OFF_RIGHT 8'h0c

// ==========================================================================
// Control fields and reset value.
`define SPTX_CTRL_FMT_LSB 0
`define SPTX_CTRL_WID_LSB 2
`define SPTX_CTRL_OSR_LSB 4
`define SPTX_CTRL_W 6
`define SPTX_CTRL_RST 6'h00

// ==========================================================================
// Status fields.
`define SPTX_STAT_LR_BIT 0
`define SPTX_STAT_HAVE_LEFT_BIT 1
`define SPTX_STAT_FRAMES_LSB 16

// ==========================================================================
// Frame geometry and word widths.
`define SPTX_WORD_MAX 24
`define SPTX_HALF_BCLKS 6'd32
`define SPTX_CNT_MAX 6'd63
`define SPTX_W16 6'd16
`define SPTX_W18 6'd18
`define SPTX_W20 6'd20
`define SPTX_W24 6'd24

// ==========================================================================
// Oversampling ratios and biphase cells per frame.
`define SPTX_OSR_768 10'd768
`define SPTX_OSR_512 10'd512
`define SPTX_OSR_384 10'd384
`define SPTX_OSR_256 10'd256
`define SPTX_CELLS_PER_FRAME 10'd128

`endif

//--- logic/sptx_pkg.sv
`default_nettype none

package sptx_pkg;

  // ========================================================================
  // Serial formats, word widths and oversampling ratios.
  typedef enum logic [1:0] {SPTX_FMT_I2S, SPTX_FMT_LJ, SPTX_FMT_RJ} sptx_fmt_t;
  typedef enum logic [1:0] {SPTX_WID_16, SPTX_WID_18, SPTX_WID_20, SPTX_WID_24} sptx_wid_t;
  typedef enum logic [1:0] {SPTX_OSR_768X, SPTX_OSR_512X, SPTX_OSR_384X, SPTX_OSR_256X} sptx_osr_t;

endpackage

`default_nettype wire

//--- logic/sptx_pair_mem.sv
`default_nettype none

`include "sptx_cfg.svh"

module sptx_pair_mem
  import sptx_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Write side.
  input wire logic wr_en,
  input wire logic [`SPTX_WORD_MAX-1:0] wr_left,
  input wire logic [`SPTX_WORD_MAX-1:0] wr_right,
  // Registered read side.
  output logic [`SPTX_WORD_MAX-1:0] rd_left,
  output logic [`SPTX_WORD_MAX-1:0] rd_right
);

  // ========================================================================
  // Two-word store, read data straight from its registers.
  logic [`SPTX_WORD_MAX-1:0] word_q [2];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_q[0] <= '0;
      word_q[1] <= '0;
    end else if (wr_en) begin
      word_q[0] <= wr_left;
      word_q[1] <= wr_right;
    end
  end

  assign rd_left = word_q[0];
  assign rd_right = word_q[1];

endmodule

`default_nettype wire

//--- logic/sptx_serial_in.sv
`default_nettype none

`include "sptx_cfg.svh"

// Overview of operation
// - Accept left-justified, I2S or right-justified words of 16, 18, 20 or 24 bits.
// - Right-justified MSB starts 32 minus width bit clocks after the channel edge.
// - Left-justified and right-justified: channel select high is left, low is right.
// - I2S: channel select low is left, high is right.
// - I2S MSB arrives one bit clock after the channel edge.
// - Left-justified MSB arrives with the channel edge, no delay.
// - Data and channel select are sampled on rising bit clock edges.
// - Format resets to I2S until software picks another.
// - Oversample clock ratio 768, 512, 384 or 256 times frame rate is a setting.
// - Biphase clock is the oversample clock divided by ratio over 128.
module sptx_serial_in
  import sptx_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Register port.
  input wire logic [`SPTX_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Serial audio pins.
  input wire logic bit_clock,
  input wire logic channel_select_clock,
  input wire logic serial_data,
  input wire logic oversample_clock,
  // Encoder side.
  output logic pair_valid,
  output logic [`SPTX_WORD_MAX-1:0] pair_left,
  output logic [`SPTX_WORD_MAX-1:0] pair_right,
  output logic biphase_tick
);

  // ========================================================================
  // Helpers.
  function automatic logic [5:0] wid_bits(input sptx_wid_t w);
    unique case (w)
      SPTX_WID_16: wid_bits = `SPTX_W16;
      SPTX_WID_18: wid_bits = `SPTX_W18;
      SPTX_WID_20: wid_bits = `SPTX_W20;
      SPTX_WID_24: wid_bits = `SPTX_W24;
    endcase
  endfunction

  function automatic logic [3:0] osr_div(input sptx_osr_t r);
    logic [9:0] n;
    n = `SPTX_OSR_256;
    unique case (r)
      SPTX_OSR_768X: n = `SPTX_OSR_768;
      SPTX_OSR_512X: n = `SPTX_OSR_512;
      SPTX_OSR_384X: n = `SPTX_OSR_384;
      SPTX_OSR_256X: n = `SPTX_OSR_256;
    endcase
    osr_div = 4'(n / `SPTX_CELLS_PER_FRAME);
  endfunction

  // ========================================================================
  // Control register.
  logic [`SPTX_CTRL_W-1:0] ctrl_q;
  wire logic wr_ctrl = reg_wr && (reg_addr == `SPTX_OFF_CTRL);
  wire logic [1:0] fmt_raw = ctrl_q[`SPTX_CTRL_FMT_LSB +: 2];
  wire sptx_fmt_t fmt = (fmt_raw == 2'h3) ? SPTX_FMT_I2S : sptx_fmt_t'(fmt_raw);
  wire sptx_wid_t wid = sptx_wid_t'(ctrl_q[`SPTX_CTRL_WID_LSB +: 2]);
  wire sptx_osr_t osr = sptx_osr_t'(ctrl_q[`SPTX_CTRL_OSR_LSB +: 2]);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `SPTX_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata[`SPTX_CTRL_W-1:0];
    end
  end

  // ========================================================================
  // Pin synchronisers: bit 0 bit clock, 1 channel select, 2 data, 3 oversample.
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] pin_q;
  wire logic [3:0] pin_d = (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_q <= '0;
    end else begin
      s1_q <= {oversample_clock, serial_data, channel_select_clock, bit_clock};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end

  wire logic bclk_rise = pin_d[0] && !pin_q[0];
  wire logic osc_rise = pin_d[3] && !pin_q[3];
  wire logic lr_in = pin_q[1];
  wire logic data_in = pin_q[2];

  // ========================================================================
  // Channel edge detection and bit position.
  logic lr_prev_q;
  logic [5:0] bit_cnt_q;
  wire logic lr_edge = bclk_rise && (lr_in != lr_prev_q);
  wire logic [5:0] pos = lr_edge ? 6'h00 :
                         (bit_cnt_q == `SPTX_CNT_MAX) ? bit_cnt_q : 6'(bit_cnt_q + 6'h01);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lr_prev_q <= 1'b0;
      bit_cnt_q <= `SPTX_CNT_MAX;
    end else if (bclk_rise) begin
      lr_prev_q <= lr_in;
      bit_cnt_q <= pos;
    end
  end

  // ========================================================================
  // Word window per format.
  wire logic [5:0] width = wid_bits(wid);
  wire logic [5:0] start = (fmt == SPTX_FMT_I2S) ? 6'h01 :
                           (fmt == SPTX_FMT_LJ) ? 6'h00 :
                           6'(`SPTX_HALF_BCLKS - width);
  wire logic [6:0] stop = 7'(start) + 7'(width) - 7'h01;
  wire logic cap_en = bclk_rise && (pos >= start) && (7'(pos) <= stop);
  wire logic word_done = cap_en && (7'(pos) == stop);
  wire logic is_left = (fmt == SPTX_FMT_I2S) ? !lr_in : lr_in;

  logic [`SPTX_WORD_MAX-1:0] sh_q;
  wire logic [`SPTX_WORD_MAX-1:0] sh_d = {sh_q[`SPTX_WORD_MAX-2:0], data_in};
  wire logic [`SPTX_WORD_MAX-1:0] wmask = 24'hff_ffff >> (6'(`SPTX_WORD_MAX) - width);
  wire logic [`SPTX_WORD_MAX-1:0] word = sh_d & wmask;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sh_q <= '0;
    end else if (cap_en) begin
      sh_q <= sh_d;
    end
  end

  // ========================================================================
  // Pair assembly: left then right, one pair per frame.
  logic [`SPTX_WORD_MAX-1:0] left_q;
  logic have_left_q;
  logic pair_valid_q;
  logic [15:0] frames_q;
  wire logic pair_wr = word_done && !is_left && have_left_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      left_q <= '0;
      have_left_q <= 1'b0;
      pair_valid_q <= 1'b0;
      frames_q <= '0;
    end else begin
      pair_valid_q <= pair_wr;
      if (word_done && is_left) begin
        left_q <= word;
        have_left_q <= 1'b1;
      end else if (word_done) begin
        have_left_q <= 1'b0;
      end
      if (pair_wr) begin
        frames_q <= frames_q + 16'h0001;
      end
    end
  end

  sptx_pair_mem u_mem (
    .clk(clk),
    .nrst(nrst),
    .wr_en(pair_wr),
    .wr_left(left_q),
    .wr_right(word),
    .rd_left(pair_left),
    .rd_right(pair_right)
  );

  assign pair_valid = pair_valid_q;

  // ========================================================================
  // Biphase clock divider.
  logic [3:0] div_cnt_q;
  logic bip_q;
  wire logic [3:0] div_n = osr_div(osr);
  wire logic div_wrap = osc_rise && (div_cnt_q >= 4'(div_n - 4'h1));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_q <= '0;
      bip_q <= 1'b0;
    end else begin
      bip_q <= div_wrap;
      if (div_wrap) begin
        div_cnt_q <= '0;
      end else if (osc_rise) begin
        div_cnt_q <= div_cnt_q + 4'h1;
      end
    end
  end

  assign biphase_tick = bip_q;

  // ========================================================================
  // Register read port.
  logic [31:0] rdata_q;
  wire logic [31:0] stat_word = {frames_q, 14'h0000, have_left_q, lr_in};
  wire logic [31:0] rd_mux =
    (reg_addr == `SPTX_OFF_CTRL) ? {26'h000_0000, ctrl_q} :
    (reg_addr == `SPTX_OFF_STATUS) ? stat_word :
    (reg_addr == `SPTX_OFF_LEFT) ? {8'h00, pair_left} :
    (reg_addr == `SPTX_OFF_RIGHT) ? {8'h00, pair_right} : 32'h0000_0000;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;

  // ========================================================================
  // Assertions.
  a_ctrl_write_osr: assert property (
    @(posedge clk) disable iff (!nrst)
    wr_ctrl |=> osr == sptx_osr_t'($past(reg_wdata[`SPTX_CTRL_OSR_LSB +: 2])))
    else $error("Oversample ratio not taken from control write.");

  a_cnt_restart: assert property (
    @(posedge clk) disable iff (!nrst)
    lr_edge |=> bit_cnt_q == 6'h00)
    else $error("Bit counter did not restart on channel edge.");

  a_cnt_step: assert property (
    @(posedge clk) disable iff (!nrst)
    bclk_rise && !lr_edge && bit_cnt_q < `SPTX_CNT_MAX |=> bit_cnt_q == $past(bit_cnt_q) + 6'h01)
    else $error("Bit counter did not advance by one.");

  a_sample_rise: assert property (
    @(posedge clk) disable iff (!nrst)
    !$stable(sh_q) |-> $past(bclk_rise))
    else $error("Shift register moved without a bit clock rise.");

  a_i2s_delay: assert property (
    @(posedge clk) disable iff (!nrst)
    fmt == SPTX_FMT_I2S && lr_edge |-> !cap_en ##0 (1'b1 ##1 !bclk_rise [*1]))
    else $error("I2S captured a bit at the channel edge.");

  a_lj_no_delay: assert property (
    @(posedge clk) disable iff (!nrst)
    fmt == SPTX_FMT_LJ && lr_edge |-> cap_en)
    else $error("Left-justified missed the MSB at the channel edge.");

  a_rj20_start: assert property (
    @(posedge clk) disable iff (!nrst)
    fmt == SPTX_FMT_RJ && wid == SPTX_WID_20 && cap_en |-> pos >= 6'd12)
    else $error("Right-justified 20-bit capture began before bit 12.");

  a_chan_select: assert property (
    @(posedge clk) disable iff (!nrst)
    word_done && lr_in == (fmt != SPTX_FMT_I2S) |=> left_q == $past(word))
    else $error("Left word not taken on the left channel select level.");

  a_pair_output: assert property (
    @(posedge clk) disable iff (!nrst)
    pair_wr |=> pair_valid && pair_left == $past(left_q) && pair_right == $past(word))
    else $error("Sample pair not handed on one cycle after completion.");

  a_width_exact: assert property (
    @(posedge clk) disable iff (!nrst)
    word_done |-> 7'(pos) - 7'(start) == 7'(width) - 7'h01)
    else $error("Word completed at the wrong width.");

  a_div_tick: assert property (
    @(posedge clk) disable iff (!nrst)
    div_wrap |=> biphase_tick ##1 !biphase_tick)
    else $error("Biphase tick not a single cycle after the divider wrap.");

  c_pair_i2s: cover property (@(posedge clk) disable iff (!nrst)
    pair_valid && fmt == SPTX_FMT_I2S);
  c_pair_lj: cover property (@(posedge clk) disable iff (!nrst)
    pair_valid && fmt == SPTX_FMT_LJ);
  c_pair_rj: cover property (@(posedge clk) disable iff (!nrst)
    pair_valid && fmt == SPTX_FMT_RJ);
  c_biphase: cover property (@(posedge clk) disable iff (!nrst)
    biphase_tick && osr == SPTX_OSR_384X);

endmodule

`default_nettype wire

//--- tb/sptx_src_model.sv
`default_nettype none

module sptx_src_model
  import sptx_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Serial audio pins.
  output logic bit_clock,
  output logic channel_select_clock,
  output logic serial_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    bit_clock = 1'b0;
    channel_select_clock = 1'b1;
    serial_data = 1'b0;
  end

  // ==========================================================================
  // One bit clock period of 80 ns; pins change only while the clock is low.
  task automatic bclk_cycle(input logic lr, input logic d);
    channel_select_clock <= lr;
    serial_data <= d;
    repeat (10) @(posedge clk);
    bit_clock <= 1'b1;
    repeat (10) @(posedge clk);
    bit_clock <= 1'b0;
  endtask

  // ==========================================================================
  // One 64 bit clock frame; unused slots carry a toggling pattern.
  task automatic send_frame(input sptx_fmt_t fmt, input int w, input logic [23:0] lw,
                            input logic [23:0] rw);
    logic left_lvl;
    logic lvl;
    int start;
    int k;
    logic [23:0] word;
    left_lvl = (fmt == SPTX_FMT_I2S) ? 1'b0 : 1'b1;
    start = (fmt == SPTX_FMT_LJ) ? 0 : (fmt == SPTX_FMT_I2S) ? 1 : 32 - w;
    @(posedge clk);
    repeat (2) bclk_cycle(~left_lvl, ~serial_data);
    for (int i = 0; i < 64; i++) begin
      word = (i < 32) ? lw : rw;
      lvl = (i < 32) ? left_lvl : ~left_lvl;
      k = (i % 32) - start;
      if (k >= 0 && k < w) begin
        bclk_cycle(lvl, word[w-1-k]);
      end else begin
        bclk_cycle(lvl, ~serial_data);
      end
    end
    serial_data <= ~serial_data;
  endtask
endmodule

`default_nettype wire

//--- tb/tb.sv
`default_nettype none

`include "sptx_cfg.svh"

module tb
  import sptx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Clock, reset and design ports.
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [`SPTX_ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic bit_clock, channel_select_clock, serial_data;
  logic oversample_clock = 1'b0;
  logic pair_valid, biphase_tick;
  logic [23:0] pair_left, pair_right, got_l, got_r;
  int fail_count = 0;
  int comparisons = 0;
  int tick_cnt = 0;
  int pv_cnt = 0;
  int widths[4] = '{16, 18, 20, 24};
  int ratios[4] = '{768, 512, 384, 256};

  always #2 clk = ~clk;

  sptx_serial_in sptx_serial_in_i (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_clock(bit_clock),
    .channel_select_clock(channel_select_clock), .serial_data(serial_data),
    .oversample_clock(oversample_clock), .pair_valid(pair_valid), .pair_left(pair_left),
    .pair_right(pair_right), .biphase_tick(biphase_tick)
  );

  sptx_src_model sptx_src_model_i (
    .clk(clk), .bit_clock(bit_clock), .channel_select_clock(channel_select_clock),
    .serial_data(serial_data)
  );

  // ==========================================================================
  // Pulse counters sample on the falling edge, clear of the launching edge.
  always @(negedge clk) begin
    if (biphase_tick === 1'b1) tick_cnt++;
    if (pair_valid === 1'b1) begin
      pv_cnt++;
      got_l = pair_left;
      got_r = pair_right;
    end
  end

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(name, exp, reg_rdata);
  endtask

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic frame_scenario(input logic [1:0] code, input sptx_fmt_t fmt,
                                input logic [1:0] wc, input int w,
                                input logic [23:0] lw, input logic [23:0] rw);
    logic [23:0] mask;
    mask = 24'hffffff >> (24 - w);
    wr(`SPTX_OFF_CTRL, {28'h0, wc, code});
    pv_cnt = 0;
    sptx_src_model_i.send_frame(fmt, w, lw, rw);
    repeat (20) @(posedge clk);
    chk("pair count", 32'h1, 32'(pv_cnt));
    chk("left word", {8'h0, lw & mask}, {8'h0, got_l});
    chk("right word", {8'h0, rw & mask}, {8'h0, got_r});
  endtask

  task automatic os_rise;
    repeat (8) @(posedge clk);
    oversample_clock <= 1'b1;
    repeat (8) @(posedge clk);
    oversample_clock <= 1'b0;
  endtask

  task automatic osr_scenario(input logic [1:0] code, input int ratio);
    int seen;
    wr(`SPTX_OFF_CTRL, {26'h0, code, 4'h0});
    seen = tick_cnt;
    for (int i = 0; i < 8 && tick_cnt == seen; i++) os_rise();
    chk("tick sync", 32'h1, 32'(tick_cnt != seen));
    tick_cnt = 0;
    repeat (24) os_rise();
    repeat (8) @(posedge clk);
    chk("biphase ticks", 32'(24 * 128 / ratio), 32'(tick_cnt));
  endtask

  task automatic reset_scenario;
    wr(`SPTX_OFF_CTRL, 32'h00000015);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(`SPTX_OFF_CTRL, 32'h0, "ctrl after reset");
    rd_chk(`SPTX_OFF_LEFT, 32'h0, "left after reset");
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(`SPTX_OFF_CTRL, 32'h0, "ctrl reset");
    wr(8'h10, 32'hffffffff);
    rd_chk(8'h10, 32'h0, "unmapped");
    wr(`SPTX_OFF_CTRL, 32'h0000003e);
    rd_chk(`SPTX_OFF_CTRL, 32'h0000003e, "ctrl");
    for (int f = 0; f < 3; f++) begin
      for (int c = 0; c < 4; c++) begin
        frame_scenario(2'(f), sptx_fmt_t'(f), 2'(c), widths[c], 24'h9a5c3e + 24'(f * 4 + c),
                       24'h3c96a5 ^ 24'(c << 20));
      end
    end
    rd_chk(`SPTX_OFF_LEFT, 32'h009a5c49, "left register");
    rd_chk(`SPTX_OFF_RIGHT, 32'h000c96a5, "right register");
    rd_chk(`SPTX_OFF_STATUS, 32'h000c0000, "status");
    frame_scenario(2'h3, SPTX_FMT_I2S, 2'h0, 16, 24'h5a0f33, 24'h0ff0c3);
    reset_scenario();
    for (int c = 0; c < 4; c++) begin
      osr_scenario(2'(c), ratios[c]);
    end
    summarize();
  end

  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule

`default_nettype wire
